// file: design/fsa_seq.sv
// Flash self-access sequencer: word read, unlock, row erase, latch load and row program
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fsa_consts.svh"
//
// How it works
// - Second instruction after the read trigger is discarded for the array access.
// - Fetched word lands in the data pair right after the access.
// - Data pair keeps the word until a new read or a software write.
// - Erase, latch load and commits need a complete, uninterrupted unlock first.
// - Setting the write trigger forces two no-operation slots.
// - Row erase or program stalls execution about 2 ms, then resumes.
// - Latch load continues right after the two forced slots, no stall.
// - Erase works only on whole rows, never single words.
// - Two preparation cycles follow the erase trigger before execution halts.
// - During the stall clocks run; only instruction execution halts.
// - After erase, execution resumes at the third instruction after the trigger.
// - Trigger bits are set by software only and cleared by hardware at completion.
// - A reset during a write sets the interrupted-program flag.
// - The unlock port is write-only and reads as zero.
// - Address pair supplies a 15-bit word address to every access except erase, which gets the row base.
module fsa_seq #(
  parameter int unsigned ERASE_CYCLES = `FSA_ERASE_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  por,
  input  wire fsa_pkg::fsa_bus_req_t bus_req,
  output      logic [7:0]            bus_rdata,
  output      fsa_pkg::fsa_arr_req_t arr_req,
  input  wire logic [13:0]           arr_rdata,
  output      logic                  force_nop,
  output      logic                  stall
);
  import fsa_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fsa_state_t   state;
  fsa_state_t   next_state;
  fsa_unlock_t  ul_state;
  fsa_unlock_t  next_ul_state;
  logic [14:0]  flash_addr;
  logic [13:0]  flash_word;
  logic         rd_bit;
  logic         wr_bit;
  logic         modify_allow;
  logic         latch_only;
  logic         row_erase_sel;
  logic         config_space_sel;
  logic         interrupted_program_flag;
  logic         busy_shadow;
  logic [15:0]  stall_cnt;

  // Register decode shared by write and read paths
  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire        ctrl_wr   = bus_req.wr && hit(bus_req.addr, `FSA_OFF_CTRL);
  wire        unlock_wr = bus_req.wr && hit(bus_req.addr, `FSA_OFF_UNLOCK);
  wire        start_rd  = ctrl_wr && bus_req.wdata[`FSA_BIT_RD] && (state == st_idle);
  wire        armed     = (ul_state == ul_armed);
  // Trigger without allow or without both keys in order is simply dropped
  wire        start_wr  = ctrl_wr && bus_req.wdata[`FSA_BIT_WR] && (state == st_idle) && !start_rd
                          && modify_allow && armed;
  wire        long_op   = row_erase_sel || !latch_only;
  wire [15:0] stall_top = 16'(ERASE_CYCLES - 1);
  wire [14:0] row_addr  = {flash_addr[14:`FSA_ROW_OFS_BITS], `FSA_ROW_OFS_BITS'h0};
  wire        stall_end = (state == st_stall) && (stall_cnt == 16'h0000);
  wire        wr_done   = stall_end || ((state == st_wr2) && !long_op);

  // ---------------------------------------------------------------
  // Unlock key tracker; any stray unlock-port write breaks the chain, except a repeated first key, which keeps it at the first step
  // ---------------------------------------------------------------
  always_comb begin
    next_ul_state = ul_state;
    if (start_wr || (ctrl_wr && bus_req.wdata[`FSA_BIT_WR])) begin
      next_ul_state = ul_idle;
    end else if (unlock_wr && bus_req.wdata == `FSA_UNLOCK_KEY2 && ul_state == ul_first) begin
      next_ul_state = ul_armed;
    end else if (unlock_wr && bus_req.wdata == `FSA_UNLOCK_KEY1) begin
      next_ul_state = ul_first;
    end else if (unlock_wr) begin
      next_ul_state = ul_idle;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer: forced slots, array access and stall
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (start_rd) begin
          next_state = st_rd1;
        end else if (start_wr) begin
          next_state = st_wr1;
        end
      end
      st_rd1:   next_state = st_rd2;
      st_rd2:   next_state = st_idle;
      st_wr1:   next_state = st_wr2;
      st_wr2:   next_state = long_op ? st_stall : st_idle;
      st_stall: next_state = stall_end ? st_idle : st_stall;
      default:  next_state = st_idle;
    endcase
  end

  // Outputs registered from the next state so the core sees them on time
  wire next_force_nop = (next_state == st_rd2) || (next_state == st_wr1) || (next_state == st_wr2);
  wire next_stall     = (next_state == st_stall);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= st_idle;
      ul_state  <= ul_idle;
      force_nop <= 1'b0;
      stall     <= 1'b0;
    end else begin
      state     <= next_state;
      ul_state  <= next_ul_state;
      force_nop <= next_force_nop;
      stall     <= next_stall;
    end
  end

  // Stall timer; clocks keep running, only execution waits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stall_cnt <= 16'h0000;
    end else if (state == st_wr2) begin
      stall_cnt <= stall_top;
    end else if (state == st_stall && stall_cnt != 16'h0000) begin
      stall_cnt <= stall_cnt - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Array request: one-cycle pulses with the 15-bit word address, or the row base for erase
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arr_req <= '0;
    end else begin
      arr_req.rd    <= (next_state == st_rd2);
      arr_req.erase <= (state == st_wr2) && row_erase_sel;
      arr_req.prog  <= (state == st_wr2) && !row_erase_sel && !latch_only;
      arr_req.load  <= (state == st_wr2) && !row_erase_sel && latch_only;
      arr_req.cfg   <= config_space_sel;
      arr_req.addr  <= ((state == st_wr2) && row_erase_sel) ? row_addr : flash_addr;
      arr_req.wdata <= flash_word;
    end
  end

  // ---------------------------------------------------------------
  // Address and data pair; a finished read overrides software
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flash_addr <= `FSA_ADDR_RESET;
      flash_word <= `FSA_WORD_RESET;
    end else begin
      if (bus_req.wr && hit(bus_req.addr, `FSA_OFF_ADDR_LO)) begin
        flash_addr[7:0] <= bus_req.wdata;
      end
      if (bus_req.wr && hit(bus_req.addr, `FSA_OFF_ADDR_HI)) begin
        flash_addr[14:8] <= bus_req.wdata[6:0];
      end
      if (arr_req.rd) begin
        flash_word <= arr_rdata;
      end else if (bus_req.wr && hit(bus_req.addr, `FSA_OFF_WORD_LO)) begin
        flash_word[7:0] <= bus_req.wdata;
      end else if (bus_req.wr && hit(bus_req.addr, `FSA_OFF_WORD_HI)) begin
        flash_word[13:8] <= bus_req.wdata[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control bits; triggers ignore software clears
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_bit           <= 1'b0;
      wr_bit           <= 1'b0;
      modify_allow     <= 1'b0;
      latch_only       <= 1'b0;
      row_erase_sel    <= 1'b0;
      config_space_sel <= 1'b0;
    end else begin
      if (start_rd) begin
        rd_bit <= 1'b1;
      end else if (state == st_rd2) begin
        rd_bit <= 1'b0;
      end
      if (start_wr) begin
        wr_bit <= 1'b1;
      end else if (wr_done) begin
        wr_bit <= 1'b0;
      end
      // Mode bits are frozen while an operation runs so it cannot change under it
      if (ctrl_wr && state == st_idle) begin
        modify_allow     <= bus_req.wdata[`FSA_BIT_ALLOW];
        latch_only       <= bus_req.wdata[`FSA_BIT_LATCH_ONLY];
        row_erase_sel    <= bus_req.wdata[`FSA_BIT_ROW_ERASE];
        config_space_sel <= bus_req.wdata[`FSA_BIT_CFG_SEL];
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupted-write detection; lives on power-on reset only so rst cannot wipe it
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge por) begin
    if (por) begin
      busy_shadow              <= 1'b0;
      interrupted_program_flag <= 1'b0;
    end else begin
      if (!rst) begin
        busy_shadow <= wr_bit;
      end
      // Set wins over a software clear in the same cycle
      if (rst && busy_shadow) begin
        interrupted_program_flag <= 1'b1;
      end else if (ctrl_wr && !bus_req.wdata[`FSA_BIT_ERR]) begin
        interrupted_program_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path: data stands one cycle, unmapped and unlock read zero
  // ---------------------------------------------------------------
  wire [7:0] ctrl_view = {1'b0, config_space_sel, row_erase_sel, latch_only,
                          interrupted_program_flag, modify_allow, wr_bit, rd_bit};
  wire [7:0] next_rdata =
    !bus_req.rd                                   ? 8'h00 :
    hit(bus_req.addr, `FSA_OFF_ADDR_LO)           ? flash_addr[7:0] :
    hit(bus_req.addr, `FSA_OFF_ADDR_HI)           ? {1'b0, flash_addr[14:8]} :
    hit(bus_req.addr, `FSA_OFF_WORD_LO)           ? flash_word[7:0] :
    hit(bus_req.addr, `FSA_OFF_WORD_HI)           ? {2'b00, flash_word[13:8]} :
    hit(bus_req.addr, `FSA_OFF_CTRL)              ? ctrl_view : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RD_SLOT: assert property (start_rd |=> !force_nop ##1 (force_nop && arr_req.rd) ##1 !force_nop)
    else $error("read access not in second slot");
  AST_RD_DATA: assert property (arr_req.rd |=> flash_word == $past(arr_rdata))
    else $error("fetched word not in data pair");
  AST_WR_NOPS: assert property (start_wr |=> force_nop [*2] ##1 !force_nop)
    else $error("write trigger did not force two slots");
  // The trigger write itself sets the mode bits, so the written value decides the kind of operation
  AST_ERASE_PREP: assert property (start_wr && bus_req.wdata[`FSA_BIT_ROW_ERASE] |=> !stall [*2] ##1 stall)
    else $error("erase stall not after two cycles");
  AST_LOAD_FREE: assert property (start_wr && bus_req.wdata[`FSA_BIT_LATCH_ONLY] && !bus_req.wdata[`FSA_BIT_ROW_ERASE]
                                  |=> !stall [*4])
    else $error("latch load stalled");
  AST_STALL_HOLD: assert property ($rose(stall) |-> stall [*8] and !force_nop [*8])
    else $error("stall ended too early");
  AST_RESUME: assert property ($fell(stall) |-> !wr_bit && state == st_idle)
    else $error("stall ended without completion");
  AST_ROW_ALIGN: assert property (arr_req.erase |-> arr_req.addr[`FSA_ROW_OFS_BITS-1:0] == '0)
    else $error("erase address not row aligned");
  AST_GATE: assert property (ctrl_wr && bus_req.wdata[`FSA_BIT_WR] && !armed && !wr_bit |=> !wr_bit)
    else $error("write started without unlock");
  AST_WR_KEEP: assert property ($fell(wr_bit) |-> $past(wr_done))
    else $error("write trigger cleared early");
  AST_UNLOCK_RD: assert property (bus_req.rd && hit(bus_req.addr, `FSA_OFF_UNLOCK) |=> bus_rdata == 8'h00)
    else $error("unlock port read not zero");
  AST_ERR_SET: assert property (@(posedge ref_clk) disable iff (por)
                                rst && busy_shadow |=> interrupted_program_flag)
    else $error("interrupted write not flagged");

  COV_READ:  cover property (start_rd ##3 !force_nop);
  COV_ERASE: cover property (start_wr && row_erase_sel ##3 stall);
  COV_LOAD:  cover property (arr_req.load);
  COV_ERR:   cover property (@(posedge ref_clk) disable iff (por) interrupted_program_flag);

endmodule

// file: pkg/fsa_consts.svh
// Constants of the flash self-access sequencer: offsets, bit positions, reset values, timing
`ifndef FSA_CONSTS_SVH
`define FSA_CONSTS_SVH

// ---------------------------------------------------------------
// Register indices on the plain register port
// ---------------------------------------------------------------
`define FSA_OFF_ADDR_LO    3'h0
`define FSA_OFF_ADDR_HI    3'h1
`define FSA_OFF_WORD_LO    3'h2
`define FSA_OFF_WORD_HI    3'h3
`define FSA_OFF_CTRL       3'h4
`define FSA_OFF_UNLOCK     3'h5

// ---------------------------------------------------------------
// Control register bit positions
// ---------------------------------------------------------------
`define FSA_BIT_RD         0
`define FSA_BIT_WR         1
`define FSA_BIT_ALLOW      2
`define FSA_BIT_ERR        3
`define FSA_BIT_LATCH_ONLY 4
`define FSA_BIT_ROW_ERASE  5
`define FSA_BIT_CFG_SEL    6

// ---------------------------------------------------------------
// Reset values, unlock keys, geometry
// ---------------------------------------------------------------
`define FSA_ADDR_RESET     15'h0000
`define FSA_WORD_RESET     14'h0000
`define FSA_UNLOCK_KEY1    8'h55
`define FSA_UNLOCK_KEY2    8'haa
`define FSA_ROW_OFS_BITS   5

// ---------------------------------------------------------------
// Timing: typical erase or program time and the clock period
// ---------------------------------------------------------------
`define FSA_ERASE_TIME_NS  2000000
`define FSA_CLK_PERIOD_NS  50
`define FSA_ERASE_CYCLES   (`FSA_ERASE_TIME_NS / `FSA_CLK_PERIOD_NS)

`endif

// file: pkg/fsa_pkg.sv
// Types shared by the flash self-access sequencer and its bench
package fsa_pkg;

  // ---------------------------------------------------------------
  // Sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    st_idle  = 6'h01,
    st_rd1   = 6'h02,
    st_rd2   = 6'h04,
    st_wr1   = 6'h08,
    st_wr2   = 6'h10,
    st_stall = 6'h20
  } fsa_state_t;

  // Unlock key tracker, one-hot
  typedef enum logic [2:0] {
    ul_idle  = 3'h1,
    ul_first = 3'h2,
    ul_armed = 3'h4
  } fsa_unlock_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fsa_bus_req_t;

  typedef struct packed {
    logic        rd;
    logic        erase;
    logic        load;
    logic        prog;
    logic        cfg;
    logic [14:0] addr;
    logic [13:0] wdata;
  } fsa_arr_req_t;

endpackage

// file: tb/fsa_flash_model.sv
// Behavioural program-flash array on the far side of the sequencer
`timescale 1ns/1ps
module fsa_flash_model
  import fsa_pkg::*;
(
  input  wire fsa_pkg::fsa_arr_req_t arr_req,
  input  wire logic                  ref_clk,
  output      logic [13:0]           arr_rdata
);
  logic [13:0] mem [32768];
  logic [13:0] lat [32];
  logic [13:0] junk = 14'h2aaa;

  // Unwritten words hold a pattern keyed on the address; latches start blank
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = i[13:0] ^ 14'h1555;
    foreach (lat[i]) lat[i] = 14'h3fff;
  end

  // Word only in the read cycle, else a toggling value so a late sample shows
  assign arr_rdata = arr_req.rd ? mem[arr_req.addr] : junk;

  // Erase blanks the whole row; program can only clear bits, then latches go blank
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (arr_req.load) lat[arr_req.addr[4:0]] <= arr_req.wdata;
    for (int i = 0; i < 32; i++) begin
      if (arr_req.erase) mem[{arr_req.addr[14:5], i[4:0]}] <= 14'h3fff;
      if (arr_req.prog) mem[{arr_req.addr[14:5], i[4:0]}] <= mem[{arr_req.addr[14:5], i[4:0]}] & lat[i];
      if (arr_req.prog) lat[i] <= 14'h3fff;
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the flash self-access sequencer
`timescale 1ns/1ps
`include "fsa_consts.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  import fsa_pkg::*;
  // ------
  // Setup
  // ------
  localparam int unsigned EC = 20;  // Short erase keeps the run brief
  localparam logic [7:0] C_RD = 8'h01 << `FSA_BIT_RD;
  localparam logic [7:0] C_WR = 8'h01 << `FSA_BIT_WR;
  localparam logic [7:0] C_AL = 8'h01 << `FSA_BIT_ALLOW;
  localparam logic [7:0] C_ER = 8'h01 << `FSA_BIT_ERR;
  localparam logic [7:0] C_LO = 8'h01 << `FSA_BIT_LATCH_ONLY;
  localparam logic [7:0] C_RE = 8'h01 << `FSA_BIT_ROW_ERASE;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         por = 1'b1;
  fsa_bus_req_t bus_req = '0;
  fsa_arr_req_t arr_req;
  fsa_arr_req_t pulse;
  logic [7:0]   bus_rdata;
  logic [13:0]  arr_rdata;
  logic [13:0]  ex;
  logic         force_nop;
  logic         stall;
  logic [7:0]   v;
  int           fail_count = 0;
  int           cmp_count = 0;
  int           n;

  // Clock at 20 MHz
  always #25 ref_clk = ~ref_clk;

  fsa_seq #(.ERASE_CYCLES(EC)) fsa_seq_i (.ref_clk(ref_clk), .rst(rst), .por(por), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .arr_req(arr_req), .arr_rdata(arr_rdata), .force_nop(force_nop), .stall(stall));
  fsa_flash_model fsa_flash_model_i (.arr_req(arr_req), .ref_clk(ref_clk), .arr_rdata(arr_rdata));

  // ------
  // Access tasks
  // ------
  function automatic logic [13:0] pat(input logic [14:0] a);
    return a[13:0] ^ 14'h1555;
  endfunction
  // A strobe holds until the next call, so writes may run back to back
  task automatic op(input logic r, w, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{rd: r, wr: w, addr: a, wdata: d};
  endtask
  task automatic cyc;
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    op(1'b0, 1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    op(1'b1, 1'b0, a, 8'h00);
    cyc;
    q = bus_rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string nm);
    rd(a, v);
    `CHK(nm, e, v)
  endtask
  task automatic set_addr(input logic [14:0] a);
    wr(`FSA_OFF_ADDR_LO, a[7:0]);
    wr(`FSA_OFF_ADDR_HI, {1'b0, a[14:8]});
  endtask
  // Back to back keys leave no room for anything to cut in
  task automatic unlock;
    wr(`FSA_OFF_UNLOCK, `FSA_UNLOCK_KEY1);
    wr(`FSA_OFF_UNLOCK, `FSA_UNLOCK_KEY2);
  endtask
  // Word read with the slot timing around the array access
  task automatic fread(input logic [14:0] a, input logic [13:0] e);
    set_addr(a);
    wr(`FSA_OFF_CTRL, 8'h00);
    wr(`FSA_OFF_CTRL, C_RD);
    cyc;
    `CHK("read slot one", 1'b0, force_nop)
    cyc;
    `CHK("read slot two", 2'b11, {force_nop, arr_req.rd})
    `CHK("read address", a, arr_req.addr)
    `CHK("read space", 1'b0, arr_req.cfg)
    cyc;
    `CHK("read slot three", 1'b0, force_nop)
    rdchk(`FSA_OFF_WORD_LO, e[7:0], "word lo");
    rdchk(`FSA_OFF_WORD_HI, {2'b00, e[13:8]}, "word hi");
    rdchk(`FSA_OFF_CTRL, 8'h00, "read trigger cleared");
  endtask
  // Write trigger: two forced slots, then a stall of exp_n cycles
  task automatic trig(input logic [7:0] c, input int exp_n);
    wr(`FSA_OFF_CTRL, c);
    cyc;
    `CHK("forced slot one", 2'b10, {force_nop, stall})
    cyc;
    `CHK("forced slot two", 2'b10, {force_nop, stall})
    cyc;
    pulse = arr_req;
    n = 0;
    while (stall === 1'b1 && n < 100) begin
      n++;
      cyc;
    end
    `CHK("stall cycles", exp_n, n)
    `CHK("resume slot", 2'b00, {force_nop, stall})
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    close_out;
  end

  // ------
  // Tests
  // ------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    por <= 1'b0;
    rdchk(`FSA_OFF_CTRL, 8'h00, "ctrl reset");
    wr(`FSA_OFF_UNLOCK, 8'h55);
    rdchk(`FSA_OFF_UNLOCK, 8'h00, "unlock port");
    rdchk(3'h6, 8'h00, "unmapped");
    // Config-space select must reach the array request before a read clears it
    wr(`FSA_OFF_CTRL, 8'h01 << `FSA_BIT_CFG_SEL);
    cyc;
    cyc;
    `CHK("config select", 1'b1, arr_req.cfg)
    rdchk(`FSA_OFF_CTRL, 8'h01 << `FSA_BIT_CFG_SEL, "config select view");
    $display("test registers done");
    ex = pat(15'h5a3c);
    fread(15'h5a3c, ex);
    wr(`FSA_OFF_ADDR_LO, 8'h77);
    rdchk(`FSA_OFF_WORD_LO, ex[7:0], "word held");
    wr(`FSA_OFF_WORD_LO, 8'hc3);
    rdchk(`FSA_OFF_WORD_LO, 8'hc3, "word written");
    $display("test read done");
    // Broken unlock with allow, then full unlock without allow
    set_addr(15'h1247);
    for (int k = 0; k < 2; k++) begin
      wr(`FSA_OFF_CTRL, k ? C_RE : C_AL | C_RE);
      wr(`FSA_OFF_UNLOCK, 8'h55);
      if (k == 0) wr(`FSA_OFF_UNLOCK, 8'h00);
      wr(`FSA_OFF_UNLOCK, 8'haa);
      wr(`FSA_OFF_CTRL, (k ? C_RE : C_AL | C_RE) | C_WR);
      repeat (3) begin
        cyc;
        `CHK("refused trigger", 2'b00, {force_nop, stall})
      end
      rdchk(`FSA_OFF_CTRL, k ? C_RE : C_AL | C_RE, "write bit clear");
    end
    $display("test refusal done");
    wr(`FSA_OFF_CTRL, C_AL | C_RE);
    unlock;
    trig(C_AL | C_RE | C_WR, EC);
    `CHK("erase pulse", 1'b1, pulse.erase)
    `CHK("erase row base", 15'h1240, pulse.addr)
    fread(15'h1243, 14'h3fff);
    fread(15'h1260, pat(15'h1260));
    $display("test erase done");
    set_addr(15'h1243);
    wr(`FSA_OFF_WORD_LO, 8'hbc);
    wr(`FSA_OFF_WORD_HI, 8'h0a);
    wr(`FSA_OFF_CTRL, C_AL | C_LO);
    unlock;
    trig(C_AL | C_LO | C_WR, 0);
    `CHK("load pulse", 2'b10, {pulse.load, pulse.prog})
    `CHK("load word", 14'h0abc, pulse.wdata)
    wr(`FSA_OFF_CTRL, C_AL);
    unlock;
    trig(C_AL | C_WR, EC);
    `CHK("program pulse", 1'b1, pulse.prog)
    fread(15'h1243, 14'h0abc);
    $display("test program done");
    // Reset in mid-erase; the bus keeps answering during the stall
    wr(`FSA_OFF_CTRL, C_AL | C_RE);
    unlock;
    wr(`FSA_OFF_CTRL, C_AL | C_RE | C_WR);
    repeat (4) cyc;
    rd(`FSA_OFF_CTRL, v);
    `CHK("busy in stall", C_WR, v & C_WR)
    wr(`FSA_OFF_CTRL, C_AL | C_RE);
    rd(`FSA_OFF_CTRL, v);
    `CHK("software clear ignored", C_WR, v & C_WR)
    `CHK("still stalled", 1'b1, stall)
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rd(`FSA_OFF_CTRL, v);
    `CHK("interrupted flag", C_ER, v & (C_ER | C_WR))
    wr(`FSA_OFF_CTRL, 8'h00);
    rdchk(`FSA_OFF_CTRL, 8'h00, "flag cleared");
    $display("test reset done");
    close_out;
  end
endmodule
